// ---- shared/rx_cfg_pkg.sv ----
`default_nettype none
package rx_cfg_pkg;
    // ------------------------------------------------------------
    // Three-level select encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_MID = 2'h1,
        LVL_HIGH = 2'h2,
        LVL_BAD = 2'h3
    } level3_t;

    // ------------------------------------------------------------
    // Path state, Gray along idle -> run -> halt
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PATH_IDLE = 2'h0,
        PATH_RUN = 2'h1,
        PATH_HALT = 2'h3
    } path_state_t;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int CHAR_W = 10;
    localparam int DATA_W = 8;
    localparam int STAT_W = 3;
    localparam int WORD_W = STAT_W + CHAR_W;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Status codes of the output register
    // ------------------------------------------------------------
    localparam logic [2:0] STAT_DATA = 3'h0;
    localparam logic [2:0] STAT_SPEC_DEF = 3'h1;
    localparam logic [2:0] STAT_SPEC_ALT = 3'h2;
    localparam logic [2:0] STAT_ERR = 3'h7;

    // ------------------------------------------------------------
    // Special character codes
    // ------------------------------------------------------------
    localparam logic [5:0] SIX_K28_NEG = 6'h0f;
    localparam logic [5:0] SIX_K28_POS = 6'h30;
    localparam logic [3:0] FOUR_ALT7_NEG = 4'h8;
    localparam logic [3:0] FOUR_ALT7_POS = 4'h7;
    localparam logic [4:0] IDX_K23 = 5'h17;
    localparam logic [4:0] IDX_K27 = 5'h1b;
    localparam logic [4:0] IDX_K28 = 5'h1c;
    localparam logic [4:0] IDX_K29 = 5'h1d;
    localparam logic [4:0] IDX_K30 = 5'h1e;
    localparam logic [7:0] ALT_BASE_EXT = 8'h08;
endpackage : rx_cfg_pkg
`default_nettype wire

// ---- shared/fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
);
    localparam int LW = $clog2(DEPTH) + 1;
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic [LW-1:0] level;
    logic [LW-1:0] level_next;

    modport user (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data, level, level_next
    );
    modport store (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, level, level_next
    );
endinterface : fifo_if
`default_nettype wire

// ---- src/elastic_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module elastic_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [LW-1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        port.push_ready = (cnt_q != LW'(DEPTH));
        port.pop_valid = (cnt_q != '0);
        port.pop_data = mem_q[rd_q];
        port.level = cnt_q;
        push = port.push_valid && port.push_ready;
        pop = port.pop_ready && port.pop_valid;
        wr_d = push ? AW'((32'(wr_q) + 1) % DEPTH) : wr_q;
        rd_d = pop ? AW'((32'(rd_q) + 1) % DEPTH) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + LW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - LW'(1);
        end
        port.level_next = cnt_d;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= port.push_data;
        end
    end
endmodule : elastic_fifo
`default_nettype wire

// ---- src/rx_decoder_clock_mode_select.sv ----
// Summary of operation
// - Decoder LOW passes raw 10-bit characters, with clock mode MID only
// - Decoder MID uses default special table
// - Decoder HIGH uses alternate special table
// - Clock mode picks source and buffer use
// - Clock mode LOW: reference loads output
// - Clock mode LOW: outputs copy reference
// - Clock mode MID: pair follows recovered rate
// - Clock mode MID bypasses elasticity buffer
`timescale 1ns/1ps
`default_nettype none
module rx_decoder_clock_mode_select #(
    parameter int DEPTH = rx_cfg_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] decoder_mode_select,
    input wire logic [1:0] receive_clock_mode_select,
    input wire logic receive_rate_select,
    input wire logic reference_clock_input,
    input wire logic rec_char_valid,
    input wire logic [rx_cfg_pkg::CHAR_W-1:0] rec_char,
    output logic rec_char_ready,
    output logic [rx_cfg_pkg::CHAR_W-1:0] rx_out_char,
    output logic [rx_cfg_pkg::STAT_W-1:0] rx_out_status,
    output logic rx_out_valid,
    output logic receive_clock_output_pair_p,
    output logic receive_clock_output_pair_n,
    output logic receive_clock_complement_output,
    output logic mode_error
);
    localparam int WW = rx_cfg_pkg::WORD_W;
    localparam int LW = $clog2(DEPTH) + 1;

    // ------------------------------------------------------------
    // Decode tables
    // ------------------------------------------------------------
    function automatic logic [5:0] six_dec(input logic [5:0] s);
        logic [5:0] r;
        r = 6'h00;
        unique case (s)
            6'b100111, 6'b011000: r = {1'b1, 5'h00};
            6'b011101, 6'b100010: r = {1'b1, 5'h01};
            6'b101101, 6'b010010: r = {1'b1, 5'h02};
            6'b110001: r = {1'b1, 5'h03};
            6'b110101, 6'b001010: r = {1'b1, 5'h04};
            6'b101001: r = {1'b1, 5'h05};
            6'b011001: r = {1'b1, 5'h06};
            6'b111000, 6'b000111: r = {1'b1, 5'h07};
            6'b111001, 6'b000110: r = {1'b1, 5'h08};
            6'b100101: r = {1'b1, 5'h09};
            6'b010101: r = {1'b1, 5'h0a};
            6'b110100: r = {1'b1, 5'h0b};
            6'b001101: r = {1'b1, 5'h0c};
            6'b101100: r = {1'b1, 5'h0d};
            6'b011100: r = {1'b1, 5'h0e};
            6'b010111, 6'b101000: r = {1'b1, 5'h0f};
            6'b011011, 6'b100100: r = {1'b1, 5'h10};
            6'b100011: r = {1'b1, 5'h11};
            6'b010011: r = {1'b1, 5'h12};
            6'b110010: r = {1'b1, 5'h13};
            6'b001011: r = {1'b1, 5'h14};
            6'b101010: r = {1'b1, 5'h15};
            6'b011010: r = {1'b1, 5'h16};
            6'b111010, 6'b000101: r = {1'b1, 5'h17};
            6'b110011, 6'b001100: r = {1'b1, 5'h18};
            6'b100110: r = {1'b1, 5'h19};
            6'b010110: r = {1'b1, 5'h1a};
            6'b110110, 6'b001001: r = {1'b1, 5'h1b};
            6'b001110, 6'b001111, 6'b110000: r = {1'b1, 5'h1c};
            6'b101110, 6'b010001: r = {1'b1, 5'h1d};
            6'b011110, 6'b100001: r = {1'b1, 5'h1e};
            6'b101011, 6'b010100: r = {1'b1, 5'h1f};
            default: r = 6'h00;
        endcase
        return r;
    endfunction : six_dec

    function automatic logic [3:0] four_dec(input logic [3:0] f);
        logic [3:0] r;
        r = 4'h0;
        unique case (f)
            4'b1011, 4'b0100: r = {1'b1, 3'h0};
            4'b1001: r = {1'b1, 3'h1};
            4'b0101: r = {1'b1, 3'h2};
            4'b1100, 4'b0011: r = {1'b1, 3'h3};
            4'b1101, 4'b0010: r = {1'b1, 3'h4};
            4'b1010: r = {1'b1, 3'h5};
            4'b0110: r = {1'b1, 3'h6};
            4'b1110, 4'b0001, 4'b0111, 4'b1000: r = {1'b1, 3'h7};
            default: r = 4'h0;
        endcase
        return r;
    endfunction : four_dec

    // Returns {status, 2'b00, data}; alt picks the special table
    function automatic logic [WW-1:0] decode_char(input logic [9:0] c, input logic alt);
        logic [5:0] six;
        logic [3:0] four;
        logic [5:0] s;
        logic [3:0] f;
        logic k28, kx7, special;
        logic [7:0] dat, alt_dat;
        six = c[9:4];
        four = c[3:0];
        k28 = (six == rx_cfg_pkg::SIX_K28_NEG) || (six == rx_cfg_pkg::SIX_K28_POS);
        if (six == rx_cfg_pkg::SIX_K28_POS) begin
            four = ~four;
        end
        s = six_dec(six);
        f = four_dec(four);
        kx7 = (c[3:0] == rx_cfg_pkg::FOUR_ALT7_NEG || c[3:0] == rx_cfg_pkg::FOUR_ALT7_POS)
            && (s[4:0] == rx_cfg_pkg::IDX_K23 || s[4:0] == rx_cfg_pkg::IDX_K27
            || s[4:0] == rx_cfg_pkg::IDX_K29 || s[4:0] == rx_cfg_pkg::IDX_K30);
        special = k28 || kx7;
        dat = {f[2:0], s[4:0]};
        alt_dat = {5'h00, f[2:0]};
        unique case (s[4:0])
            rx_cfg_pkg::IDX_K23: alt_dat = rx_cfg_pkg::ALT_BASE_EXT;
            rx_cfg_pkg::IDX_K27: alt_dat = rx_cfg_pkg::ALT_BASE_EXT + 8'h01;
            rx_cfg_pkg::IDX_K29: alt_dat = rx_cfg_pkg::ALT_BASE_EXT + 8'h02;
            rx_cfg_pkg::IDX_K30: alt_dat = rx_cfg_pkg::ALT_BASE_EXT + 8'h03;
            default: alt_dat = {5'h00, f[2:0]};
        endcase
        if (!(s[5] && f[3])) begin
            return {rx_cfg_pkg::STAT_ERR, 2'h0, 8'h00};
        end else if (special && alt) begin
            return {rx_cfg_pkg::STAT_SPEC_ALT, 2'h0, alt_dat};
        end else if (special) begin
            return {rx_cfg_pkg::STAT_SPEC_DEF, 2'h0, dat};
        end
        return {rx_cfg_pkg::STAT_DATA, 2'h0, dat};
    endfunction : decode_char

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rx_cfg_pkg::path_state_t state_q, state_d;
    rx_cfg_pkg::level3_t dec_q, dec_d, clk_q, clk_d;
    logic rate_q, rate_d;
    logic ready_q, ready_d, valid_q, valid_d, err_q, err_d;
    logic [WW-1:0] out_q, out_d;
    logic ref_dly_q, ref_dly_d, div_q, div_d;
    logic pair_q, pair_d, comp_q, comp_d;
    logic pair_n_q, pair_n_d;
    logic legal, elastic, accept, running;
    logic [WW-1:0] word;

    fifo_if #(.WIDTH(WW), .DEPTH(DEPTH)) buf_if ();

    elastic_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .port(buf_if.store)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        dec_d = dec_q;
        clk_d = clk_q;
        rate_d = rate_q;
        valid_d = 1'b0;
        out_d = out_q;
        div_d = div_q;
        ref_dly_d = reference_clock_input;
        pair_d = pair_q;
        comp_d = comp_q;
        running = (state_q == rx_cfg_pkg::PATH_RUN);
        legal = (clk_q == rx_cfg_pkg::LVL_LOW || clk_q == rx_cfg_pkg::LVL_MID)
            && (dec_q != rx_cfg_pkg::LVL_BAD)
            && !(dec_q == rx_cfg_pkg::LVL_LOW && clk_q != rx_cfg_pkg::LVL_MID);
        err_d = !legal;
        elastic = (clk_q == rx_cfg_pkg::LVL_LOW);
        accept = running && rec_char_valid && ready_q;
        if (dec_q == rx_cfg_pkg::LVL_LOW) begin
            word = {rx_cfg_pkg::STAT_DATA, rec_char};
        end else begin
            word = decode_char(rec_char, dec_q == rx_cfg_pkg::LVL_HIGH);
        end
        buf_if.push_valid = accept && elastic;
        buf_if.push_data = word;
        buf_if.pop_ready = running && elastic && reference_clock_input;
        unique case (state_q)
            rx_cfg_pkg::PATH_IDLE: state_d = legal ? rx_cfg_pkg::PATH_RUN : rx_cfg_pkg::PATH_HALT;
            rx_cfg_pkg::PATH_RUN: state_d = rx_cfg_pkg::PATH_RUN;
            rx_cfg_pkg::PATH_HALT: state_d = rx_cfg_pkg::PATH_HALT;
            default: state_d = rx_cfg_pkg::PATH_HALT;
        endcase
        if (running && elastic) begin
            if (reference_clock_input && buf_if.pop_valid) begin
                out_d = buf_if.pop_data;
                valid_d = 1'b1;
            end
        end else if (accept) begin
            out_d = word;
            valid_d = 1'b1;
        end
        if (elastic) begin
            ready_d = running && (buf_if.level_next != LW'(DEPTH));
            pair_d = pair_q ^ ref_dly_q;
            comp_d = ~pair_d;
        end else begin
            ready_d = (state_d == rx_cfg_pkg::PATH_RUN);
            comp_d = comp_q ^ ref_dly_q;
            if (accept) begin
                div_d = ~div_q;
                pair_d = pair_q ^ (rate_q | div_q);
            end
        end
        // Own flop so the negative leg leaves a register too
        pair_n_d = ~pair_d;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= rx_cfg_pkg::PATH_IDLE;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            err_q <= 1'b0;
            out_q <= '0;
            ref_dly_q <= 1'b0;
            div_q <= 1'b0;
            pair_q <= 1'b0;
            comp_q <= 1'b1;
            pair_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            err_q <= err_d;
            out_q <= out_d;
            ref_dly_q <= ref_dly_d;
            div_q <= div_d;
            pair_q <= pair_d;
            comp_q <= comp_d;
            pair_n_q <= pair_n_d;
        end
    end

    // Selects sampled while reset is held, frozen afterwards
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dec_q <= rx_cfg_pkg::level3_t'(decoder_mode_select);
            clk_q <= rx_cfg_pkg::level3_t'(receive_clock_mode_select);
            rate_q <= receive_rate_select;
        end else begin
            dec_q <= dec_d;
            clk_q <= clk_d;
            rate_q <= rate_d;
        end
    end

    assign rec_char_ready = ready_q;
    assign rx_out_char = out_q[rx_cfg_pkg::CHAR_W-1:0];
    assign rx_out_status = out_q[WW-1:rx_cfg_pkg::CHAR_W];
    assign rx_out_valid = valid_q;
    assign receive_clock_output_pair_p = pair_q;
    assign receive_clock_output_pair_n = pair_n_q;
    assign receive_clock_complement_output = comp_q;
    assign mode_error = err_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_run_mid;
        running && clk_q == rx_cfg_pkg::LVL_MID;
    endsequence
    sequence s_run_low;
        running && clk_q == rx_cfg_pkg::LVL_LOW;
    endsequence

    a_raw_char_pass: assert property (
        s_run_mid ##0 (dec_q == rx_cfg_pkg::LVL_LOW && rec_char_valid && ready_q)
        |=> rx_out_valid && rx_out_char == $past(rec_char) && rx_out_status == rx_cfg_pkg::STAT_DATA)
        else $error("raw character not passed");
    a_default_table: assert property (
        s_run_mid ##0 (dec_q == rx_cfg_pkg::LVL_MID && rec_char_valid && ready_q && rec_char == 10'h0fa)
        |=> rx_out_status == rx_cfg_pkg::STAT_SPEC_DEF && rx_out_char == 10'h0bc)
        else $error("default special table wrong");
    a_alt_table: assert property (
        s_run_mid ##0 (dec_q == rx_cfg_pkg::LVL_HIGH && rec_char_valid && ready_q && rec_char == 10'h0fa)
        |=> rx_out_status == rx_cfg_pkg::STAT_SPEC_ALT && rx_out_char == 10'h005)
        else $error("alternate special table wrong");
    a_elastic_fill: assert property (
        s_run_low ##0 (rec_char_valid && ready_q && !reference_clock_input)
        |=> buf_if.level == $past(buf_if.level) + LW'(1))
        else $error("elasticity buffer not written");
    a_ref_loads_out: assert property (
        s_run_low ##1 rx_out_valid |-> $past(reference_clock_input))
        else $error("output loaded without reference");
    a_ref_clock_copy: assert property (
        s_run_low ##0 reference_clock_input |-> ##2 (pair_q != $past(pair_q)
        && receive_clock_complement_output == !pair_q))
        else $error("receive clocks do not copy reference");
    a_rec_rate_full: assert property (
        s_run_mid ##0 (rate_q && rec_char_valid && ready_q) |=> pair_q != $past(pair_q))
        else $error("pair not following recovered clock");
    a_buffer_bypass: assert property (
        s_run_mid |-> buf_if.level == '0 && ready_q)
        else $error("elasticity buffer used in bypass");
    a_mode_flag: assert property (
        ##1 (clk_q == rx_cfg_pkg::LVL_HIGH) |=> mode_error && state_q != rx_cfg_pkg::PATH_RUN)
        else $error("illegal clock mode not flagged");
    a_config_static: assert property (
        running |=> $stable(dec_q) && $stable(clk_q) && $stable(rate_q))
        else $error("configuration changed while running");
endmodule : rx_decoder_clock_mode_select
`default_nettype wire

// ---- verification/host_cfg_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_cfg_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] want_dec,
    input wire logic [1:0] want_clk,
    input wire logic want_rate,
    input wire logic misbehave,
    output logic [1:0] decoder_mode_select,
    output logic [1:0] receive_clock_mode_select,
    output logic receive_rate_select
);
    // ------------------------------------------------------------
    // Selects move only while the receiver is held in reset
    // ------------------------------------------------------------
    initial begin
        decoder_mode_select = 2'h1;
        receive_clock_mode_select = 2'h1;
        receive_rate_select = 1'h1;
    end

    always @(negedge mclk) begin
        if (sys_rst) begin
            decoder_mode_select <= want_dec;
            receive_rate_select <= want_rate;
            if (misbehave) begin
                receive_clock_mode_select <= want_clk;
            end else if (want_dec == 2'h0 || want_clk[1]) begin
                receive_clock_mode_select <= 2'h1;
            end else begin
                receive_clock_mode_select <= want_clk;
            end
        end
    end
endmodule : host_cfg_model
`default_nettype wire

// ---- verification/test_rx_decoder_clock_mode_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rx_decoder_clock_mode_select;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic [1:0] want_dec = 2'h1;
    logic [1:0] want_clk = 2'h1;
    logic want_rate = 1'h1;
    logic misbehave = 1'h0;
    logic ref_en = 1'h0;
    logic [1:0] decoder_mode_select;
    logic [1:0] receive_clock_mode_select;
    logic receive_rate_select;
    logic reference_clock_input = 1'h0;
    logic rec_char_valid = 1'h0;
    logic [rx_cfg_pkg::CHAR_W-1:0] rec_char = 10'h000;
    logic rec_char_ready;
    logic [rx_cfg_pkg::CHAR_W-1:0] rx_out_char;
    logic [rx_cfg_pkg::STAT_W-1:0] rx_out_status;
    logic rx_out_valid;
    logic pair_p;
    logic pair_n;
    logic complement;
    logic mode_error;
    logic [13:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;
    int takes = 0;
    int ref_cnt = 0;
    int out_cnt = 0;
    logic [9:0] code_tab [7] = '{10'h274, 10'h2aa, 10'h0fa, 10'h305, 10'h0f4, 10'h3a8, 10'h000};
    logic [12:0] dflt_tab [7] = '{13'h0000, 13'h00b5, 13'h04bc, 13'h04bc, 13'h041c, 13'h04f7, 13'h1c00};
    logic [12:0] alt_tab [7] = '{13'h0000, 13'h00b5, 13'h0805, 13'h0805, 13'h0800, 13'h0808, 13'h1c00};

    always #4 mclk = ~mclk;

    host_cfg_model i_host_cfg_model (.mclk(mclk), .sys_rst(sys_rst), .want_dec(want_dec), .want_clk(want_clk),
        .want_rate(want_rate), .misbehave(misbehave), .decoder_mode_select(decoder_mode_select),
        .receive_clock_mode_select(receive_clock_mode_select), .receive_rate_select(receive_rate_select));

    rx_decoder_clock_mode_select i_rx_decoder_clock_mode_select (.mclk(mclk), .sys_rst(sys_rst),
        .decoder_mode_select(decoder_mode_select), .receive_clock_mode_select(receive_clock_mode_select),
        .receive_rate_select(receive_rate_select), .reference_clock_input(reference_clock_input),
        .rec_char_valid(rec_char_valid), .rec_char(rec_char), .rec_char_ready(rec_char_ready),
        .rx_out_char(rx_out_char), .rx_out_status(rx_out_status), .rx_out_valid(rx_out_valid),
        .receive_clock_output_pair_p(pair_p), .receive_clock_output_pair_n(pair_n),
        .receive_clock_complement_output(complement), .mode_error(mode_error));

    // ------------------------------------------------------------
    // Reference ticks, take and tick counters
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        reference_clock_input <= ref_en && ($urandom_range(2) == 0);
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            takes <= 0;
            ref_cnt <= 0;
        end else begin
            takes <= takes + int'(rec_char_valid && rec_char_ready);
            ref_cnt <= ref_cnt + int'(reference_clock_input);
        end
    end

    task automatic cmp_out(input logic [13:0] e, input logic [9:0] c, input logic [2:0] s);
        checks++;
        if (c !== e[9:0] || (e[13] && s !== e[12:10])) begin
            n_mismatch++;
            $display("[ERR] rx_out expected %h/%h seen %h/%h", e[12:10], e[9:0], s, c);
        end
    endtask : cmp_out

    task automatic cmp_bit(input string what, input logic e, input logic s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", what, e, s);
        end
    endtask : cmp_bit

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        if (!sys_rst && rx_out_valid === 1'h1) begin
            out_cnt++;
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[ERR] rx_out expected none seen %h", rx_out_char);
            end else begin
                cmp_out(exp_q.pop_front(), rx_out_char, rx_out_status);
            end
        end
    end

    task automatic send_char(input logic [9:0] c, input logic [13:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        rec_char_valid = 1'h1;
        rec_char = c;
        exp_q.push_back(e);
        while (rec_char_ready !== 1'h1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        cmp_bit("rec_char_ready", 1'h1, rec_char_ready);
        @(posedge mclk);
    endtask : send_char

    task automatic idle;
        @(negedge mclk);
        rec_char_valid = 1'h0;
        rec_char = ~rec_char;
    endtask : idle

    task automatic do_reset(input logic [1:0] d, input logic [1:0] k, input logic r, input logic bad);
        @(negedge mclk);
        ref_en = 1'h0;
        rec_char_valid = 1'h0;
        want_dec = d;
        want_clk = k;
        want_rate = r;
        misbehave = bad;
        sys_rst = 1'h1;
        repeat (8) @(negedge mclk);
        sys_rst = 1'h0;
        repeat (3) @(negedge mclk);
        cmp_bit("mode_error", bad, mode_error);
    endtask : do_reset

    task automatic chk_clocks(input logic mid, input logic rate);
        logic exp_p;
        ref_en = 1'h1;
        repeat (30) @(negedge mclk);
        ref_en = 1'h0;
        repeat (4) @(negedge mclk);
        exp_p = mid ? (rate ? takes[0] : takes[1]) : ref_cnt[0];
        cmp_bit("pair_p", exp_p, pair_p);
        cmp_bit("pair_n", ~exp_p, pair_n);
        cmp_bit("complement", ~ref_cnt[0], complement);
    endtask : chk_clocks

    task automatic end_test(input string name);
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) begin
            @(negedge mclk);
        end
        cmp_bit("drained", 1'h1, exp_q.size() == 0);
        $display("test %s done", name);
    endtask : end_test

    task automatic halt_test(input logic [1:0] d, input logic [1:0] k);
        do_reset(d, k, 1'h1, 1'h1);
        rec_char_valid = 1'h1;
        repeat (6) @(negedge mclk);
        cmp_bit("rec_char_ready", 1'h0, rec_char_ready);
        rec_char_valid = 1'h0;
        $display("test halt %h/%h done", d, k);
    endtask : halt_test

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [9:0] c;
        int held;
        c = 10'($urandom(78));
        do_reset(2'h0, 2'h1, 1'h1, 1'h0);
        for (int i = 0; i < 20; i++) begin
            c = 10'($urandom_range(1023));
            send_char(c, {1'h1, rx_cfg_pkg::STAT_DATA, c});
        end
        idle();
        chk_clocks(1'h1, 1'h1);
        end_test("bypass");
        do_reset(2'h1, 2'h1, 1'h1, 1'h0);
        for (int i = 0; i < 7; i++) begin
            send_char(code_tab[i], {1'h1, dflt_tab[i]});
        end
        idle();
        repeat (2) @(negedge mclk);
        cmp_bit("mid_no_buffer", 1'h1, exp_q.size() == 0);
        chk_clocks(1'h1, 1'h1);
        end_test("default_table");
        do_reset(2'h2, 2'h1, 1'h0, 1'h0);
        for (int i = 0; i < 7; i++) begin
            send_char(code_tab[i], {1'h1, alt_tab[i]});
        end
        idle();
        chk_clocks(1'h1, 1'h0);
        end_test("alt_table");
        do_reset(2'h1, 2'h0, 1'h1, 1'h0);
        held = out_cnt;
        for (int i = 0; i < 16; i++) begin
            send_char(code_tab[i % 7], {1'h1, dflt_tab[i % 7]});
        end
        @(negedge mclk);
        rec_char = code_tab[2];
        cmp_bit("rec_char_ready", 1'h0, rec_char_ready);
        cmp_bit("held_until_tick", 1'h1, out_cnt == held);
        ref_en = 1'h1;
        send_char(code_tab[2], {1'h1, dflt_tab[2]});
        idle();
        end_test("reference_clocked");
        chk_clocks(1'h0, 1'h1);
        halt_test(2'h1, 2'h2);
        halt_test(2'h0, 2'h0);
        halt_test(2'h3, 2'h1);
        tally_and_finish();
    end

    initial begin
        #(8 * 20000);
        n_mismatch++;
        $display("[ERR] watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule : test_rx_decoder_clock_mode_select
`default_nettype wire
